// >>> tap_pkg.sv
// Constants, states and carrier types for the test access port controller
package tap_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int IR_W  = 8;               // Instruction stage width
    localparam int BSC_W = 40;              // Boundary cell chain width
    localparam int BCC_W = 11;              // Boundary control chain width

    // ------------------------------------------------------------
    // Reset and capture values
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0]  IR_RESET   = 8'hff;        // Bypass opcode
    localparam logic [IR_W-1:0]  IR_CAPTURE = 8'h81;        // Scan-path check
    localparam logic [BSC_W-1:0] BSC_RESET  = 40'h00_0000_0000;
    localparam logic [BCC_W-1:0] BCC_RESET  = 11'h002;      // Signature, no mask
    localparam logic             BYP_CAPTURE = 1'h0;        // Bypass capture

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TLR_MAX_TCK = 5;         // Test-clock cycles back to reset

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, IDLE, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    // Data register picked for scan
    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_CELLS, SEL_CONTROL
    } dr_sel_t;

    // Decoded instruction
    typedef struct packed {
        logic    test_mode;                 // Normal function inhibited
        logic    run_test;                  // Boundary run test opcode
        dr_sel_t sel;                       // Selected data register
    } decode_t;

    // Word handed to the core on a data update
    typedef struct packed {
        logic             to_control;       // Control chain, else cells
        logic [BSC_W-1:0] data;             // Updated latch contents
    } upd_word_t;

endpackage : tap_pkg

// >>> tap_controller.sv
// Test access port controller with instruction and data registers
`timescale 1ns/1ps
// Function
// R01: Sixteen-state machine stepped by mode select
// R02: Six states may hold, ten leave
// R03: Powers up in reset, normal function
// R04: Mode select high five cycles resets
// R05: Instruction resets to all ones, bypass
// R06: Reset clears boundary cell chain
// R07: Reset presets control chain to signature
// R08: Run test only while in idle
// R09: Select states act nothing, leave next
// R10: Capture data on edge leaving capture; the control chain is left unchanged
// R11: Shift enters path, drive least bit
// R12: One shift per rise, not entry cycle
// R13: Exit one releases data out on fall
// R14: Exit may return to shift, no capture
// R15: Pause holds state and register contents
// R16: Data latches update on update fall
// R17: Instruction captures fixed 10000001 pattern
// R18: Instruction latches load on update fall
// R19: Latch per bit except bypass register
// R20: Eight-bit instruction decodes mode and register
// R21: Even parity, bit seven is parity
// R22: Unsupported opcodes behave as bypass
// R23: One register in serial path only
// R24: Sample on rise, outputs on fall
// R25: Chains of forty, eleven, one bits
// R26: Bypass captures logic zero
// R27: Standard controller transition graph
module tap_controller #(
    parameter int BSC_WIDTH = 40,           // Boundary cell chain length
    parameter int BCC_WIDTH = 11            // Control chain length
) (
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    // Test port pins
    input  wire logic                         tck,
    input  wire logic                         tms,
    input  wire logic                         tdi,
    output logic                              tdo,
    output logic                              tdo_oe_n,
    // Core side
    input  wire logic [tap_pkg::BSC_W-1:0]    cell_capture,
    output logic [tap_pkg::IR_W-1:0]          instruction,
    output logic                              test_mode,
    output logic                              run_test,
    output logic [tap_pkg::BSC_W-1:0]         cell_latch,
    output logic [tap_pkg::BCC_W-1:0]         control_latch,
    // Update word stream
    output logic                              upd_valid,
    input  wire logic                         upd_ready,
    output tap_pkg::upd_word_t                upd_word
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (BSC_WIDTH != tap_pkg::BSC_W || BCC_WIDTH != tap_pkg::BCC_W) // R25
    begin : g_bad_width
        $error("chain widths must match the package");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                tck_s;     // Clock synchroniser
        logic [1:0]                tms_s;     // Mode synchroniser
        logic [1:0]                tdi_s;     // Data synchroniser
        logic                      tck_p;     // Previous synced clock
        tap_pkg::tap_state_t       st;        // Controller state
        logic [tap_pkg::IR_W-1:0]  ir_sh;     // Instruction shift stage
        logic [tap_pkg::IR_W-1:0]  ir;        // Instruction latches
        tap_pkg::decode_t          dec;       // Decoded instruction
        logic [tap_pkg::BSC_W-1:0] bsc_sh;    // Cell chain shift stage
        logic [tap_pkg::BSC_W-1:0] bsc;       // Cell chain latches
        logic [tap_pkg::BCC_W-1:0] bcc_sh;    // Control shift stage
        logic [tap_pkg::BCC_W-1:0] bcc;       // Control latches
        logic                      byp;       // Bypass stage, no latch
        logic                      tdo;       // Data out level
        logic                      oe_n;      // Data out enable, low drives
        logic                      run;       // Run test active
        logic                      pend;      // Update word awaits room
        tap_pkg::upd_word_t        pend_w;    // Waiting update word
        logic [1:0]                bv;        // Buffer entry valid
        tap_pkg::upd_word_t [1:0]  be;        // Buffer entries
    } state_t;

    state_t s_q;                              // Registered state
    state_t s_d;                              // Next state

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    function automatic tap_pkg::decode_t decode(
        input logic [tap_pkg::IR_W-1:0] op
    );
        tap_pkg::decode_t r;
        r = '{test_mode: 1'b0, run_test: 1'b0, sel: tap_pkg::SEL_BYPASS};
        // Parity bit 7 is part of each code; wrong parity is bypass
        case (op)
            8'h00, 8'h03, 8'h8b:                   // Cells, test
            begin
                r.sel       = tap_pkg::SEL_CELLS;
                r.test_mode = 1'b1;
            end
            8'h82, 8'h0a, 8'h0c:                   // Cells, normal
                r.sel = tap_pkg::SEL_CELLS;
            8'h06, 8'h87, 8'h8d:                   // Bypass, test
                r.test_mode = 1'b1;
            8'h09:                                 // Boundary run test
            begin
                r.test_mode = 1'b1;
                r.run_test  = 1'b1;
            end
            8'h8e:                                 // Control, normal
                r.sel = tap_pkg::SEL_CONTROL;
            8'h0f:                                 // Control, test
            begin
                r.sel       = tap_pkg::SEL_CONTROL;
                r.test_mode = 1'b1;
            end
            default:                               // R22
                r.sel = tap_pkg::SEL_BYPASS;
        endcase
        return r;
    endfunction : decode

    // ------------------------------------------------------------
    // Controller transition
    // ------------------------------------------------------------
    function automatic tap_pkg::tap_state_t next_st(
        input tap_pkg::tap_state_t c,
        input logic                m
    );
        tap_pkg::tap_state_t n;
        n = tap_pkg::TLR;
        case (c)
            tap_pkg::TLR:    n = m ? tap_pkg::TLR    : tap_pkg::IDLE;
            tap_pkg::IDLE:   n = m ? tap_pkg::SEL_DR : tap_pkg::IDLE;
            tap_pkg::SEL_DR: n = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: n = m ? tap_pkg::EX1_DR : tap_pkg::SHF_DR;
            tap_pkg::SHF_DR: n = m ? tap_pkg::EX1_DR : tap_pkg::SHF_DR;
            tap_pkg::EX1_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR: n = m ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::SHF_DR;
            tap_pkg::UPD_DR: n = m ? tap_pkg::SEL_DR : tap_pkg::IDLE;
            tap_pkg::SEL_IR: n = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: n = m ? tap_pkg::EX1_IR : tap_pkg::SHF_IR;
            tap_pkg::SHF_IR: n = m ? tap_pkg::EX1_IR : tap_pkg::SHF_IR;
            tap_pkg::EX1_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR: n = m ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::SHF_IR;
            tap_pkg::UPD_IR: n = m ? tap_pkg::SEL_DR : tap_pkg::IDLE;
            default:         n = tap_pkg::TLR;
        endcase
        return n;
    endfunction : next_st

    // ------------------------------------------------------------
    // Edge detection on synced test clock
    // ------------------------------------------------------------
    logic rise;                               // Test clock rose
    logic fall;                               // Test clock fell
    logic stall;                              // Update word waits to be pushed
    logic tms_i;                              // Synced mode select
    logic tdi_i;                              // Synced data in
    logic in_ready;                           // Buffer accepts a word
    logic pop;                                // Buffer head taken

    assign stall    = s_q.pend;
    assign rise     = s_q.tck_s[1] & ~s_q.tck_p & ~stall;    // R24
    assign fall     = ~s_q.tck_s[1] & s_q.tck_p & ~stall;    // R24
    assign tms_i    = s_q.tms_s[1];
    assign tdi_i    = s_q.tdi_s[1];
    assign in_ready = ~s_q.bv[1];
    assign pop      = s_q.bv[0] & upd_ready;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // Two-flop synchronisers; only the second stage is read
        s_d.tck_s = {s_q.tck_s[0], tck};
        s_d.tms_s = {s_q.tms_s[0], tms};
        s_d.tdi_s = {s_q.tdi_s[0], tdi};
        // Edges seen while stalled are replayed after the push
        if (!stall)
        begin
            s_d.tck_p = s_q.tck_s[1];
        end

        // Rising edge: capture, shift, step the controller
        if (rise)
        begin
            case (s_q.st)
                tap_pkg::CAP_DR:                           // R10
                begin
                    case (s_q.dec.sel)
                        tap_pkg::SEL_CELLS:
                            s_d.bsc_sh = cell_capture;
                        tap_pkg::SEL_CONTROL:
                            s_d.bcc_sh = s_q.bcc_sh;       // Left unchanged
                        default:
                            s_d.byp = tap_pkg::BYP_CAPTURE; // R26
                    endcase
                end
                tap_pkg::SHF_DR:                           // R12 R23
                begin
                    case (s_q.dec.sel)
                        tap_pkg::SEL_CELLS:
                            s_d.bsc_sh = {tdi_i, s_q.bsc_sh[tap_pkg::BSC_W-1:1]};
                        tap_pkg::SEL_CONTROL:
                            s_d.bcc_sh = {tdi_i, s_q.bcc_sh[tap_pkg::BCC_W-1:1]};
                        default:
                            s_d.byp = tdi_i;
                    endcase
                end
                tap_pkg::CAP_IR:                           // R17
                    s_d.ir_sh = tap_pkg::IR_CAPTURE;
                tap_pkg::SHF_IR:                           // R12 R23
                    s_d.ir_sh = {tdi_i, s_q.ir_sh[tap_pkg::IR_W-1:1]};
                default:                                   // R09 R15
                    s_d.ir_sh = s_q.ir_sh;
            endcase
            s_d.st = next_st(s_q.st, tms_i);               // R01 R02 R04 R14 R27
        end

        // Falling edge: data out, updates
        if (fall)
        begin
            case (s_q.st)
                tap_pkg::SHF_DR:                           // R11 R24
                begin
                    s_d.oe_n = 1'b0;
                    case (s_q.dec.sel)
                        tap_pkg::SEL_CELLS:   s_d.tdo = s_q.bsc_sh[0];
                        tap_pkg::SEL_CONTROL: s_d.tdo = s_q.bcc_sh[0];
                        default:              s_d.tdo = s_q.byp;
                    endcase
                end
                tap_pkg::SHF_IR:                           // R11
                begin
                    s_d.oe_n = 1'b0;
                    s_d.tdo  = s_q.ir_sh[0];
                end
                tap_pkg::UPD_DR:                           // R16 R19
                begin
                    s_d.oe_n = 1'b1;
                    if (s_q.dec.sel == tap_pkg::SEL_CELLS)
                    begin
                        s_d.bsc          = s_q.bsc_sh;
                        s_d.pend         = 1'b1;
                        s_d.pend_w.to_control = 1'b0;
                        s_d.pend_w.data  = s_q.bsc_sh;
                    end
                    else if (s_q.dec.sel == tap_pkg::SEL_CONTROL)
                    begin
                        s_d.bcc          = s_q.bcc_sh;
                        s_d.pend         = 1'b1;
                        s_d.pend_w.to_control = 1'b1;
                        s_d.pend_w.data  = {{(tap_pkg::BSC_W-tap_pkg::BCC_W){1'b0}},
                                            s_q.bcc_sh};
                    end
                end
                tap_pkg::UPD_IR:                           // R18 R20 R21
                begin
                    s_d.oe_n = 1'b1;
                    s_d.ir   = s_q.ir_sh;
                    s_d.dec  = decode(s_q.ir_sh);
                end
                default:                                   // R13
                    s_d.oe_n = 1'b1;
            endcase
        end

        // Test-logic reset holds every test register except the bypass stage at its reset value
        if (s_q.st == tap_pkg::TLR)                        // R03
        begin
            s_d.ir     = tap_pkg::IR_RESET;                // R05
            s_d.ir_sh  = tap_pkg::IR_RESET;
            s_d.dec    = decode(tap_pkg::IR_RESET);
            s_d.bsc    = tap_pkg::BSC_RESET;               // R06
            s_d.bsc_sh = tap_pkg::BSC_RESET;
            s_d.bcc    = tap_pkg::BCC_RESET;               // R07
            s_d.bcc_sh = tap_pkg::BCC_RESET;
            s_d.oe_n   = 1'b1;
        end

        // Run test only while idle under the run-test opcode
        s_d.run = s_q.dec.run_test && (s_q.st == tap_pkg::IDLE); // R08

        // Two-entry buffer: pop shifts the tail forward
        if (pop)
        begin
            s_d.be[0] = s_q.be[1];
            s_d.bv    = {1'b0, s_q.bv[1]};
        end
        // Push waiting word into the first free slot
        if (s_q.pend && (in_ready || pop))
        begin
            s_d.pend = 1'b0;
            if (!s_d.bv[0])
            begin
                s_d.be[0] = s_q.pend_w;
                s_d.bv[0] = 1'b1;
            end
            else
            begin
                s_d.be[1] = s_q.pend_w;
                s_d.bv[1] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_q        <= '0;
            s_q.tck_s  <= 2'h0;
            s_q.tms_s  <= 2'h3;
            s_q.tdi_s  <= 2'h3;
            s_q.st     <= tap_pkg::TLR;                    // R03
            s_q.ir     <= tap_pkg::IR_RESET;               // R05
            s_q.ir_sh  <= tap_pkg::IR_RESET;
            s_q.dec    <= '{test_mode: 1'b0, run_test: 1'b0,
                            sel: tap_pkg::SEL_BYPASS};
            s_q.bsc    <= tap_pkg::BSC_RESET;              // R06
            s_q.bsc_sh <= tap_pkg::BSC_RESET;
            s_q.bcc    <= tap_pkg::BCC_RESET;              // R07
            s_q.bcc_sh <= tap_pkg::BCC_RESET;
            s_q.oe_n   <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign tdo           = s_q.tdo;
    assign tdo_oe_n      = s_q.oe_n;
    assign instruction   = s_q.ir;
    assign test_mode     = s_q.dec.test_mode;
    assign run_test      = s_q.run;
    assign cell_latch    = s_q.bsc;
    assign control_latch = s_q.bcc;
    assign upd_valid     = s_q.bv[0];
    assign upd_word      = s_q.be[0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [2:0] tms_run;                      // Rises with mode select high
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tms_run <= 3'h0;
        else if (rise)
            tms_run <= !tms_i ? 3'h0 : (tms_run == 3'h5 ? 3'h5 : tms_run + 3'h1);
    end

    sequence s_fall_in(tap_pkg::tap_state_t x);
        fall && s_q.st == x;
    endsequence

    sequence s_rise_in(tap_pkg::tap_state_t x);
        rise && s_q.st == x;
    endsequence

    property p_five_high;
        tms_run == 3'h5 |-> s_q.st == tap_pkg::TLR;
    endproperty
    a_five_high: assert property (p_five_high) else $error("not reset after five"); // R04

    property p_ir_reset;
        s_q.st == tap_pkg::TLR |=> s_q.ir == tap_pkg::IR_RESET && s_q.dec.sel == tap_pkg::SEL_BYPASS;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("instruction not reset"); // R05

    property p_chain_reset;
        s_q.st == tap_pkg::TLR |=> s_q.bsc == '0 && s_q.bcc == tap_pkg::BCC_RESET;
    endproperty
    a_chain_reset: assert property (p_chain_reset) else $error("chains not reset"); // R06

    property p_sel_leave;
        s_rise_in(tap_pkg::SEL_DR) |=> s_q.st inside {tap_pkg::CAP_DR, tap_pkg::SEL_IR};
    endproperty
    a_sel_leave: assert property (p_sel_leave) else $error("select state held"); // R09

    property p_ir_capture;
        s_rise_in(tap_pkg::CAP_IR) |=> s_q.ir_sh == tap_pkg::IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("bad capture pattern"); // R17

    property p_drive_shift;
        s_fall_in(tap_pkg::SHF_IR) |=> !s_q.oe_n && s_q.tdo == $past(s_q.ir_sh[0]);
    endproperty
    a_drive_shift: assert property (p_drive_shift) else $error("data out not driven"); // R11

    property p_release_exit;
        s_fall_in(tap_pkg::EX1_DR) |=> s_q.oe_n;
    endproperty
    a_release_exit: assert property (p_release_exit) else $error("data out not released"); // R13

    property p_pause_hold;
        s_rise_in(tap_pkg::PAU_DR) ##0 !tms_i |=> s_q.st == tap_pkg::PAU_DR && $stable(s_q.bsc_sh);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause lost data"); // R15

    property p_ir_update;
        s_fall_in(tap_pkg::UPD_IR) |=> s_q.ir == $past(s_q.ir_sh);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not updated"); // R18

    property p_run_idle;
        run_test |-> $past(s_q.st) == tap_pkg::IDLE;
    endproperty
    a_run_idle: assert property (p_run_idle) else $error("run test outside idle"); // R08

endmodule : tap_controller

// >>> tap_tester.sv
// Boundary-scan tester model that drives the test port
`timescale 1ns/1ps
module tap_tester (
    // Pacing clock
    input  wire logic clock,
    // Test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    // ----------------------------------------
    // Idle: test clock still, pulled-up lines high
    // ----------------------------------------
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 800 ns test-clock cycle; data out read just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge clock);
        tms = m;
        tdi = d;
        repeat (3) @(negedge clock);
        o   = tdo_oe_n ? ~tdo : tdo;        // Released line reads inverted
        tck = 1'b1;
        repeat (4) @(negedge clock);
        tck = 1'b0;
    endtask : step
    // Full scan from idle back to idle, low bit first
    task automatic scan(input logic ir, input int n, input logic [39:0] din,
                        output logic [39:0] dout, output logic oe_any);
        logic o;
        dout   = '0;
        oe_any = 1'b0;
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);                // Capture
        step(1'b0, 1'b1, o);                // Into shift
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
            oe_any  = oe_any | tdo_oe_n;
        end
        step(1'b1, 1'b1, o);                // Exit to update
        step(1'b0, 1'b1, o);                // Back to idle
    endtask : scan
endmodule : tap_tester

// >>> tb_tap_controller.sv
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
module tb_tap_controller;
    logic                       clock, rst_n, tck, tms, tdi, tdo, tdo_oe_n, o, oe_any;
    logic                       test_mode, run_test, upd_valid, upd_ready;
    logic [tap_pkg::IR_W-1:0]   instruction;
    logic [tap_pkg::BSC_W-1:0]  cell_capture, cell_latch, dout;
    logic [tap_pkg::BCC_W-1:0]  control_latch;
    tap_pkg::upd_word_t         upd_word, last_word;
    int                         bad_count = 0, comparisons = 0, words = 0, cycles = 0, n;
    // ----------------------------------------
    // Clock, timeout, update word sink
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (upd_valid === 1'b1 && upd_ready)
        begin
            last_word = upd_word;
            words++;
        end
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    tap_tester tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
    tap_controller dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .cell_capture(cell_capture), .instruction(instruction),
        .test_mode(test_mode), .run_test(run_test), .cell_latch(cell_latch),
        .control_latch(control_latch), .upd_valid(upd_valid), .upd_ready(upd_ready),
        .upd_word(upd_word));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Reset-state values, then step to idle
    task automatic reset_vals();
        check(instruction, 8'hff);
        check(control_latch, 11'h002);
        check(cell_latch, 40'h0);
        check(test_mode, 1'b0);
        check(tdo_oe_n, 1'b1);
        tester.step(1'b0, 1'b1, o);
    endtask : reset_vals
    // Instruction scan with capture pattern and output checks
    task automatic ir_load(input logic [7:0] op);
        tester.scan(1'b1, 8, {32'h0, op}, dout, oe_any);
        check(dout[7:0], 8'h81);
        check(oe_any, 1'b0);
        check(tdo_oe_n, 1'b1);
        check(instruction, op);
    endtask : ir_load
    // Cell scan suspended in pause, resumed through exit two
    task automatic pause_resume(input logic [39:0] din);
        tester.step(1'b1, 1'b1, o);
        tester.step(1'b0, 1'b1, o);
        tester.step(1'b0, 1'b1, o);
        for (int i = 0; i < 40; i++)
        begin
            if (i == 8)
            begin
                tester.step(1'b0, 1'b1, o);
                tester.step(1'b0, 1'b1, o);
                check(tdo_oe_n, 1'b1);
                tester.step(1'b1, 1'b1, o);
                tester.step(1'b0, 1'b1, o);
            end
            tester.step(i == 7 || i == 39, din[i], o);
            dout[i] = o;
        end
        tester.step(1'b1, 1'b1, o);
        tester.step(1'b0, 1'b1, o);
        check(dout, cell_capture);
        check(cell_latch, din);
        check(last_word, {1'b0, din});
    endtask : pause_resume
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n        = 1'b0;
        upd_ready    = 1'b1;
        cell_capture = 40'h3c_0f0f_1e1e;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        reset_vals();
        $display("Test reset values done");
        ir_load(8'h82);
        check(test_mode, 1'b0);
        tester.scan(1'b0, 40, 40'ha5_1234_5678, dout, oe_any);
        check(dout, cell_capture);
        check(oe_any, 1'b0);
        check(cell_latch, 40'ha5_1234_5678);
        check(last_word, {1'b0, 40'ha5_1234_5678});
        $display("Test cell chain done");
        pause_resume(40'h5a_a55a_0ff0);
        $display("Test pause resume done");
        ir_load(8'h0f);
        check(test_mode, 1'b1);
        tester.scan(1'b0, 11, 40'h155, dout, oe_any);
        check(dout[10:0], 11'h002);
        check(control_latch, 11'h155);
        check({last_word.to_control, last_word.data[10:0]}, {1'b1, 11'h155});
        $display("Test control chain done");
        ir_load(8'h01);
        check(test_mode, 1'b0);
        n = words;
        tester.scan(1'b0, 4, 40'hb, dout, oe_any);
        check(dout[3:0], 4'h6);
        check(words, n);
        $display("Test bypass done");
        ir_load(8'h09);
        check(run_test, 1'b1);
        tester.step(1'b1, 1'b1, o);
        check(run_test, 1'b0);
        $display("Test run idle done");
        repeat (4) tester.step(1'b1, 1'b1, o);
        reset_vals();
        $display("Test mode-select reset done");
        summarize();
    end
endmodule : tb_tap_controller
